/* File: verilog/rtc_pkg.sv */
// constants for the periodic wakeup timer
package rtc_pkg;
	// ==========================================
	// register offsets
	localparam logic [7:0] OFS_STATUS_CONTROL = 8'h00;
	localparam logic [7:0] OFS_COUNT_READBACK = 8'h04;
	localparam logic [7:0] OFS_ALARM_COMPARE = 8'h08;
	localparam logic [7:0] OFS_PERIODIC_INTERVAL = 8'h0C;
	localparam logic [7:0] OFS_WAKE_ENABLES = 8'h10;
	localparam logic [7:0] OFS_POWER_STATUS = 8'h14;
	// ==========================================
	// timer_status_control fields
	localparam int B_RUN_EN = 0;
	localparam int B_SRC_LO = 1;
	localparam int B_DIV512_EN = 3;
	localparam int B_ALARM_IRQ_EN = 4;
	localparam int B_WRAP_FLAG_EN = 5;
	localparam int B_PERIODIC_EN = 6;
	localparam int B_PERIODIC_IRQ_EN = 7;
	localparam int B_ALARM_FLAG = 8;
	localparam int B_WRAP_FLAG = 9;
	localparam int B_PERIODIC_FLAG = 10;
	// wake enables / wake capture fields
	localparam int B_WK_ALARM = 0;
	localparam int B_WK_WRAP = 1;
	localparam int B_WK_PERIODIC = 2;
	// ==========================================
	// sizes and reset values
	localparam int CNT_W = 32;
	localparam int ALARM_W = 12;
	localparam int ALARM_LSB = 10;
	localparam int PER_W = 10;
	localparam int PRE32_W = 5;
	localparam int PRE512_W = 9;
	localparam int SYNC_STAGES = 2;
	localparam logic [10:0] CTRL_RESET = 11'h000;
	localparam logic [2:0] WAKE_RESET = 3'h0;
	// ==========================================
	// clock source encodings
	typedef enum logic [1:0] {
		SRC_IRC32K = 2'h0,
		SRC_OSC32K = 2'h1,
		SRC_IRC16M = 2'h2
	} source_t;
endpackage

/* File: verilog/rtc_periodic_wakeup_timer.sv */
// periodic wakeup timer: counter, alarm, rollover, periodic compare, apb slave
// Contract
// [R1] 32-bit counter, cleared while run enable low
// [R2] source select among three slow clocks
// [R3] optional divide-by-512, idle when bypassed
// [R4] fixed divide-by-32 ahead of counter
// [R5] software stops counter before changing source
// [R6] software enables crystal before selecting it
// [R7] count readable, may lag live value
// [R8] bits 10-21 equal alarm value sets flag
// [R9] alarm irq while flag and enable set
// [R10] write one clears alarm flag
// [R11] alarm value changed only while stopped
// [R12] alarm wake first, then flag, capture wake
// [R13] rollover flagged only with wrap enable
// [R14] rollover wakes with both enables, captured
// [R15] rollover irq needs wrap and alarm enable
// [R16] periodic target equals count plus interval
// [R17] interval changed only while periodic disabled
// [R18] periodic flag, irq, write-one clear
// [R19] periodic wake first, then flag, capture
// [R20] counting continues in debug mode
// [R21] only power-on resets clear the counter
// [R22] events pass two-stage synchronizer before flags
//
// The APB register port and the register addresses were decided locally.
module rtc_periodic_wakeup_timer (
	// clock and power-on reset
	input wire logic clk_sys,
	input wire logic nrst,
	// oscillator inputs
	input wire logic irc32k_in,
	input wire logic osc32k_in,
	input wire logic irc16m_in,
	// power mode controller
	input wire logic low_power_mode,
	output logic wake_request,
	output logic alarm_irq,
	output logic periodic_irq,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr
);
	// ==========================================
	// reset release
	logic [1:0] rst_sync_q;
	logic rst_n;
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	// ==========================================
	// registers
	localparam int ALARM_W_C = rtc_pkg::ALARM_W;
	logic [10:0] ctrl_q;
	logic [ALARM_W_C-1:0] alarm_val_q;
	logic [rtc_pkg::PER_W-1:0] interval_q;
	logic [2:0] wake_en_q;
	logic [2:0] wake_cap_q;
	logic [rtc_pkg::CNT_W-1:0] count_q;
	logic [rtc_pkg::CNT_W-1:0] readback_q;

	logic run_en;
	logic [1:0] src_sel;
	assign run_en = ctrl_q[rtc_pkg::B_RUN_EN];
	assign src_sel = ctrl_q[rtc_pkg::B_SRC_LO +: 2];

	// ==========================================
	// oscillator sampling: pins are asynchronous to clk_sys
	logic [2:0] osc_pins;
	logic [2:0] osc_tick;
	assign osc_pins = {irc16m_in, osc32k_in, irc32k_in};
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_osc
			logic [2:0] smp_q;
			always_ff @(posedge clk_sys or negedge rst_n) begin
				if (!rst_n) begin
					smp_q <= 3'h0;
				end else begin
					smp_q <= {smp_q[1:0], osc_pins[gi]};
				end
			end
			// edge taken from stages two and three only
			assign osc_tick[gi] = smp_q[1] & ~smp_q[2];
		end
	endgenerate

	// ==========================================
	// source select and prescalers
	logic [rtc_pkg::PRE512_W-1:0] pre512_q;
	logic div512_active;
	logic src_tick;
	logic [rtc_pkg::PRE32_W-1:0] pre32_q;
	logic cnt_tick;

	assign div512_active = ctrl_q[rtc_pkg::B_DIV512_EN] && run_en &&
		(src_sel == rtc_pkg::SRC_IRC16M);

	// bypassed divider stays frozen at zero to save power
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pre512_q <= '0;
		end else if (!div512_active) begin
			pre512_q <= '0; // [R3]
		end else if (osc_tick[2]) begin
			pre512_q <= pre512_q + 1'b1; // [R3]
		end
	end

	always_comb begin
		unique case (src_sel)
			rtc_pkg::SRC_IRC32K: src_tick = osc_tick[0]; // [R2]
			rtc_pkg::SRC_OSC32K: src_tick = osc_tick[1]; // [R2] [R6]
			rtc_pkg::SRC_IRC16M: src_tick = osc_tick[2] &
				(!ctrl_q[rtc_pkg::B_DIV512_EN] || (&pre512_q)); // [R2] [R3]
			default: src_tick = 1'b0;
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pre32_q <= '0;
		end else if (!run_en) begin
			pre32_q <= '0;
		end else if (src_tick) begin
			pre32_q <= pre32_q + 1'b1; // [R4]
		end
	end
	assign cnt_tick = run_en && src_tick && (&pre32_q); // [R4]

	// ==========================================
	// counter; no debug halt input exists, so it keeps running
	// only nrst (power-on and supply resets) reaches this flop
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			count_q <= '0; // [R21]
		end else if (!run_en) begin
			count_q <= '0; // [R1]
		end else if (cnt_tick) begin
			count_q <= count_q + 1'b1; // [R1] [R20]
		end
	end

	// one cycle behind the live count
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			readback_q <= '0;
		end else begin
			readback_q <= count_q; // [R7]
		end
	end

	// ==========================================
	// compare events, one pulse on the count step that hits
	logic [rtc_pkg::CNT_W-1:0] count_nx;
	logic [rtc_pkg::CNT_W-1:0] target_q;
	logic per_en;
	logic per_en_q;
	logic [2:0] evt_raw;
	assign count_nx = count_q + 1'b1;
	assign per_en = ctrl_q[rtc_pkg::B_PERIODIC_EN];
	assign evt_raw[rtc_pkg::B_WK_ALARM] = cnt_tick &&
		(count_nx[rtc_pkg::ALARM_LSB +: ALARM_W_C] == alarm_val_q); // [R8]
	assign evt_raw[rtc_pkg::B_WK_WRAP] = cnt_tick && (&count_q) &&
		ctrl_q[rtc_pkg::B_WRAP_FLAG_EN]; // [R13]
	assign evt_raw[rtc_pkg::B_WK_PERIODIC] = cnt_tick && per_en && per_en_q &&
		(count_nx == target_q); // [R16]

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			per_en_q <= 1'b0;
			target_q <= '0;
		end else begin
			per_en_q <= per_en;
			if (per_en && !per_en_q) begin
				target_q <= count_q + rtc_pkg::CNT_W'(interval_q); // [R16]
			end else if (evt_raw[rtc_pkg::B_WK_PERIODIC]) begin
				target_q <= target_q + rtc_pkg::CNT_W'(interval_q); // [R16]
			end
		end
	end

	// ==========================================
	// event synchronizer, then one extra stage so wake leads flag
	logic [2:0] evt_s1_q;
	logic [2:0] evt_s2_q;
	logic [2:0] evt_d_q;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			evt_s1_q <= 3'h0;
			evt_s2_q <= 3'h0;
			evt_d_q <= 3'h0;
		end else begin
			evt_s1_q <= evt_raw; // [R22]
			evt_s2_q <= evt_s1_q; // [R22]
			evt_d_q <= evt_s2_q;
		end
	end

	// ==========================================
	// apb decode
	logic wr_acc;
	logic [2:0] flag_clr;
	logic [2:0] cap_clr;
	logic [2:0] wake_hit;
	logic [2:0] flags;
	assign wr_acc = psel && penable && pready && pwrite;
	assign flag_clr = (wr_acc && paddr == rtc_pkg::OFS_STATUS_CONTROL) ?
		pwdata[rtc_pkg::B_ALARM_FLAG +: 3] : 3'h0; // [R10] [R18]
	assign cap_clr = (wr_acc && paddr == rtc_pkg::OFS_POWER_STATUS) ?
		pwdata[2:0] : 3'h0;
	assign wake_hit = evt_s2_q & wake_en_q & {3{low_power_mode}}; // [R12] [R14] [R19]
	assign flags = ctrl_q[rtc_pkg::B_ALARM_FLAG +: 3];

	// control bits and flags; a set in the clearing cycle wins
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_q <= rtc_pkg::CTRL_RESET;
		end else begin
			if (wr_acc && paddr == rtc_pkg::OFS_STATUS_CONTROL) begin
				ctrl_q[7:0] <= pwdata[7:0];
			end
			ctrl_q[rtc_pkg::B_ALARM_FLAG +: 3] <= (flags & ~flag_clr) | evt_d_q; // [R8] [R13] [R18]
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			alarm_val_q <= '0;
			interval_q <= '0;
			wake_en_q <= rtc_pkg::WAKE_RESET;
		end else if (wr_acc) begin
			// values are taken as written; software keeps them stable
			if (paddr == rtc_pkg::OFS_ALARM_COMPARE) begin
				alarm_val_q <= pwdata[ALARM_W_C-1:0]; // [R11]
			end
			if (paddr == rtc_pkg::OFS_PERIODIC_INTERVAL) begin
				interval_q <= pwdata[rtc_pkg::PER_W-1:0]; // [R17]
			end
			if (paddr == rtc_pkg::OFS_WAKE_ENABLES) begin
				wake_en_q <= pwdata[2:0];
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			wake_cap_q <= 3'h0;
		end else begin
			wake_cap_q <= (wake_cap_q & ~cap_clr) | wake_hit; // [R12] [R14] [R19]
		end
	end

	// ==========================================
	// outputs to power controller and interrupt logic
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			wake_request <= 1'b0;
			alarm_irq <= 1'b0;
			periodic_irq <= 1'b0;
		end else begin
			wake_request <= |wake_hit; // [R12] [R14] [R19]
			alarm_irq <= (flags[0] && ctrl_q[rtc_pkg::B_ALARM_IRQ_EN]) || // [R9]
				(flags[1] && ctrl_q[rtc_pkg::B_WRAP_FLAG_EN] &&
				ctrl_q[rtc_pkg::B_ALARM_IRQ_EN]); // [R15]
			periodic_irq <= flags[2] && ctrl_q[rtc_pkg::B_PERIODIC_IRQ_EN]; // [R18]
		end
	end

	// ==========================================
	// apb answer: ready in the first access cycle
	logic mapped;
	logic [31:0] rd_mux;
	assign mapped = (paddr[1:0] == 2'h0) && (paddr <= rtc_pkg::OFS_POWER_STATUS);
	always_comb begin
		rd_mux = 32'h0;
		unique case (paddr)
			rtc_pkg::OFS_STATUS_CONTROL: rd_mux = {21'h0, ctrl_q};
			rtc_pkg::OFS_COUNT_READBACK: rd_mux = readback_q; // [R7]
			rtc_pkg::OFS_ALARM_COMPARE: rd_mux = {20'h0, alarm_val_q};
			rtc_pkg::OFS_PERIODIC_INTERVAL: rd_mux = {22'h0, interval_q};
			rtc_pkg::OFS_WAKE_ENABLES: rd_mux = {29'h0, wake_en_q};
			rtc_pkg::OFS_POWER_STATUS: rd_mux = {29'h0, wake_cap_q};
			default: rd_mux = 32'h0;
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0;
		end else begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && !mapped;
			prdata <= (psel && !penable && !pwrite) ? rd_mux : 32'h0;
		end
	end
endmodule

/* File: testbench/rtc_checker_assertions.sv */
// port checker for the periodic wakeup timer
module rtc_checker (
	// clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// power side
	input wire logic low_power_mode,
	input wire logic wake_request,
	input wire logic alarm_irq,
	input wire logic periodic_irq,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	timeunit 1ns;
	timeprecision 1ps;
	// ========
	// properties
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	logic setup;
	logic wr0;
	logic bad;
	assign setup = psel && !penable;
	assign wr0 = psel && penable && pready && pwrite && paddr == 8'h00;
	assign bad = paddr > 8'h14 || paddr[1:0] != 2'h0;
	a_ready_one: assert property (pready |=> !pready) else $error("pready held");
	a_ready_setup: assert property (setup |=> pready) else $error("pready late");
	a_err_bad: assert property (setup && bad |=> pslverr) else $error("no slave error");
	a_err_good: assert property (setup && !bad |=> !pslverr) else $error("stray error");
	a_rdata_idle: assert property (!pready |-> prdata == 32'h0) else $error("prdata not 0");
	a_wake_sleep:
		assert property (wake_request |-> low_power_mode || $past(low_power_mode))
		else $error("wake outside sleep");
	a_wake_pulse: assert property (wake_request |=> !wake_request) else $error("wake held");
	a_alarm_off:
		assert property (wr0 && !pwdata[4] |-> ##2 !alarm_irq) else $error("alarm irq");
	a_periodic_off:
		assert property (wr0 && !pwdata[7] |-> ##2 !periodic_irq) else $error("per irq");
	c_wake: cover property (wake_request);
	c_alarm: cover property (alarm_irq);
	c_periodic: cover property (periodic_irq);
endmodule
bind rtc_periodic_wakeup_timer rtc_checker u_chk (.clk_sys(clk_sys), .nrst(nrst),
	.low_power_mode(low_power_mode), .wake_request(wake_request), .alarm_irq(alarm_irq),
	.periodic_irq(periodic_irq), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

/* File: testbench/lpm_model.sv */
// sleep/stop controller model facing the wake output
module lpm_model (
	// clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// request and wake
	input wire logic sleep_req,
	input wire logic wake_request,
	output logic low_power_mode
);
	timeunit 1ns;
	timeprecision 1ps;
	// ========
	// mode state, wake wins over a new sleep
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			low_power_mode <= 1'b0;
		end else if (wake_request) begin
			low_power_mode <= 1'b0;
		end else if (sleep_req) begin
			low_power_mode <= 1'b1;
		end
	end
endmodule

/* File: testbench/tb.sv */
// self-checking bench for the periodic wakeup timer
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin miscompares++; \
	$display("[FAIL] %s expected %h seen %h", n, e, g); end end
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	// ========
	// signals
	logic clk_sys = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic sleep_req = 1'b0;
	logic [2:0] src = 3'h0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd, rs = 32'h11EC;
	logic pready, pslverr, er, wake_request, low_power_mode, alarm_irq, periodic_irq;
	int miscompares = 0, samples_checked = 0;
	initial forever #5 clk_sys = ~clk_sys;
	rtc_periodic_wakeup_timer DUT (.clk_sys(clk_sys), .nrst(nrst), .irc32k_in(src[0]),
		.osc32k_in(src[1]), .irc16m_in(src[2]), .low_power_mode(low_power_mode),
		.wake_request(wake_request), .alarm_irq(alarm_irq), .periodic_irq(periodic_irq),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr));
	lpm_model u_lpm (.clk_sys(clk_sys), .nrst(nrst), .sleep_req(sleep_req),
		.wake_request(wake_request), .low_power_mode(low_power_mode));
	// ========
	// model and helpers
	function automatic logic [31:0] xs(input logic [31:0] x);
		logic [31:0] y;
		y = x ^ (x << 13);
		y = y ^ (y >> 17);
		return y ^ (y << 5);
	endfunction
	function automatic int ecount(input int n, input bit dv);
		return dv ? n / 16384 : n / 32;
	endfunction
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do begin
			@(posedge clk_sys);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (pready !== 1'b1) begin
			miscompares++;
			print_verdict();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		`CHK(nm, e, rd & m)
	endtask
	// random high and low times, then let events settle
	task automatic tick(input int p, input int n);
		repeat (n) begin
			rs = xs(rs);
			src[p] <= 1'b1;
			repeat (2 + rs[0]) @(posedge clk_sys);
			src[p] <= 1'b0;
			repeat (2 + rs[1]) @(posedge clk_sys);
		end
		repeat (12) @(posedge clk_sys);
	endtask
	task automatic nap();
		sleep_req <= 1'b1;
		@(posedge clk_sys);
		sleep_req <= 1'b0;
	endtask
	task automatic print_verdict();
		if (miscompares == 0 && samples_checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// ========
	// scenarios
	initial begin
		repeat (2) @(posedge clk_sys);
		nrst <= 1'b1;
		repeat (3) @(posedge clk_sys);
		bus(1'b0, 8'h18, 32'h0);
		`CHK("unmapped", 1'b1, er)
		bus(1'b0, 8'h02, 32'h0);
		`CHK("misaligned", 1'b1, er)
		rchk("ctrl reset", 8'h00, 32'hFFFFFFFF, 32'h0);
		rs = xs(rs);
		bus(1'b1, 8'h08, rs);
		rchk("alarm value", 8'h08, 32'hFFFFFFFF, rs & 32'hFFF);
		for (int s = 0; s < 4; s++) begin
			bus(1'b1, 8'h00, 32'h0);
			bus(1'b1, 8'h00, 32'(s * 2 + 1));
			tick(s % 3, 64);
			rchk("count", 8'h04, 32'hFFFFFFFF, (s == 3) ? 0 : 32'(ecount(64, 0)));
		end
		bus(1'b1, 8'h00, 32'h0);
		bus(1'b1, 8'h00, 32'h0D);
		tick(2, 96);
		rchk("divided", 8'h04, 32'hFFFFFFFF, 32'(ecount(96, 1)));
		bus(1'b1, 8'h00, 32'h0);
		bus(1'b1, 8'h08, 32'h0);
		bus(1'b1, 8'h14, 32'h7);
		bus(1'b1, 8'h10, 32'h1);
		nap();
		bus(1'b1, 8'h00, 32'h11);
		tick(0, 32);
		`CHK("alarm irq", 1'b1, alarm_irq)
		`CHK("alarm woke", 1'b0, low_power_mode)
		rchk("alarm capture", 8'h14, 32'h7, 32'h1);
		bus(1'b1, 8'h00, 32'h11);
		rchk("alarm flag", 8'h00, 32'h100, 32'h100);
		bus(1'b1, 8'h00, 32'h111);
		rchk("alarm clear", 8'h00, 32'h100, 32'h0);
		bus(1'b1, 8'h00, 32'h0);
		bus(1'b1, 8'h0C, 32'h2);
		bus(1'b1, 8'h10, 32'h4);
		bus(1'b1, 8'h14, 32'h7);
		nap();
		bus(1'b1, 8'h00, 32'hC1);
		tick(0, 64);
		`CHK("periodic irq", 1'b1, periodic_irq)
		`CHK("periodic woke", 1'b0, low_power_mode)
		rchk("periodic capture", 8'h14, 32'h7, 32'h4);
		bus(1'b1, 8'h00, 32'h4C1);
		rchk("periodic clear", 8'h00, 32'h400, 32'h0);
		tick(0, 64);
		rchk("periodic again", 8'h00, 32'h400, 32'h400);
		bus(1'b1, 8'h00, 32'h0);
		// readback trails the live count, so let the clear reach it
		repeat (2) @(posedge clk_sys);
		rchk("count cleared", 8'h04, 32'hFFFFFFFF, 32'h0);
		bus(1'b1, 8'h00, 32'h1);
		tick(0, 32);
		rchk("count before reset", 8'h04, 32'hFFFFFFFF, 32'(ecount(32, 0)));
		nrst <= 1'b0;
		repeat (2) @(posedge clk_sys);
		nrst <= 1'b1;
		repeat (3) @(posedge clk_sys);
		rchk("count after reset", 8'h04, 32'hFFFFFFFF, 32'h0);
		print_verdict();
	end
endmodule
